// ===== common/pll_ctrl_consts.vh
// constants for the synthesizer divider, pump and lock detect control
`ifndef PLL_CTRL_CONSTS_VH
`define PLL_CTRL_CONSTS_VH

`define REF_DIV_W      14
`define FB_DIV_W       19
`define FRAC_W         24
`define OUT_SEL_W      5
`define OUT_SEL_LOCK   5'h01
`define OUT_SEL_REFDIV 5'h09
`define OUT_SEL_FBDIV  5'h0A
`define MOD_MODE_A     2'h0
`define HIT_W          14
`define HIT_SHIFT_BASE 6
`define DIFF_W         12
`define DIFF_MAX       12'hFFF
`define SYS_CLK_KHZ    40000
`define ANALOG_WIN_NS  10
`define TMR_NS_SPD0    8
`define TMR_NS_SPD1    9
`define TMR_NS_SPD2    9
`define TMR_NS_SPD3    10
`endif

// ===== src/pulse_divider.v
// divides a stream of one-cycle input pulses by a programmable ratio
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
  parameter WIDTH = 14
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire             pulseIn,
  input  wire [WIDTH-1:0] ratio,
  output reg              pulseOut_q
);
  reg  [WIDTH-1:0] count_q;
  wire [WIDTH-1:0] countNext = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
  // a zero ratio behaves like one so the output never stalls
  wire             wrap      = (countNext >= ratio);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q    <= {WIDTH{1'b0}};
      pulseOut_q <= 1'b0;
    end else begin
      pulseOut_q <= pulseIn & wrap;
      if (pulseIn) begin
        count_q <= wrap ? {WIDTH{1'b0}} : countNext;
      end
    end
  end
endmodule // pulse_divider
`default_nettype wire

// ===== src/pll_dividers_lock_detect.v
// divider chain, detector/pump control and window lock detector
`timescale 1ns/1ps
`default_nettype none
`include "pll_ctrl_consts.vh"
module pll_dividers_lock_detect (
  input  wire                    sys_clk,
  input  wire                    rst_n,
  input  wire                    refIn,
  input  wire                    vcoIn,
  input  wire [`REF_DIV_W-1:0]   refRatio,
  input  wire                    rfHalfSel,
  input  wire [`FB_DIV_W-1:0]    fbInteger,
  input  wire [`FRAC_W-1:0]      fbFraction,
  input  wire                    fracEnable,
  input  wire [1:0]              modulatorMode,
  input  wire [2:0]              resetTrim,
  input  wire                    pumpUpEnable,
  input  wire                    pumpDownEnable,
  input  wire                    pump_force_raise,
  input  wire                    pump_force_lower,
  input  wire                    detector_force_midpoint,
  input  wire                    lockEnable,
  input  wire                    windowDigital,
  input  wire [1:0]              timerSpeed,
  input  wire [2:0]              timerMultiplier,
  input  wire [2:0]              hitCountSel,
  input  wire [`OUT_SEL_W-1:0]   outSelect,
  input  wire                    pinHoldLock,
  input  wire                    pinLockGate,
  input  wire                    serialReadActive,
  input  wire                    serialReadData,
  output reg                     pumpRaiseOutput_q,
  output reg                     pump_lower_output_q,
  output reg                     midSourceEnable_q,
  output reg                     lockStatus_q,
  output reg                     lock_or_serial_out_pin_q,
  output reg                     refDivPulse_q,
  output reg                     fbDivPulse_q
);
  // window timer and analog window widths in sys_clk cycles, rounded down, at least one
  localparam integer ANA_CYC_RAW = `ANALOG_WIN_NS * `SYS_CLK_KHZ / 1000000;
  localparam integer ANA_CYC     = (ANA_CYC_RAW < 1) ? 1 : ANA_CYC_RAW;
  localparam integer T0_RAW      = `TMR_NS_SPD0 * `SYS_CLK_KHZ / 1000000;
  localparam integer T1_RAW      = `TMR_NS_SPD1 * `SYS_CLK_KHZ / 1000000;
  localparam integer T2_RAW      = `TMR_NS_SPD2 * `SYS_CLK_KHZ / 1000000;
  localparam integer T3_RAW      = `TMR_NS_SPD3 * `SYS_CLK_KHZ / 1000000;
  localparam integer T0_CYC      = (T0_RAW < 1) ? 1 : T0_RAW;
  localparam integer T1_CYC      = (T1_RAW < 1) ? 1 : T1_RAW;
  localparam integer T2_CYC      = (T2_RAW < 1) ? 1 : T2_RAW;
  localparam integer T3_CYC      = (T3_RAW < 1) ? 1 : T3_RAW;

  localparam [2:0] S_IDLE     = 3'h1;
  localparam [2:0] S_REFFIRST = 3'h2;
  localparam [2:0] S_VCOFIRST = 3'h4;

  // pin synchronisers; stage one feeds stage two only
  reg refS1_q;
  reg refS2_q;
  reg refS3_q;
  reg vcoS1_q;
  reg vcoS2_q;
  reg vcoS3_q;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refS1_q <= 1'b0;
      refS2_q <= 1'b0;
      refS3_q <= 1'b0;
      vcoS1_q <= 1'b0;
      vcoS2_q <= 1'b0;
      vcoS3_q <= 1'b0;
    end else begin
      refS1_q <= refIn;
      refS2_q <= refS1_q;
      refS3_q <= refS2_q;
      vcoS1_q <= vcoIn;
      vcoS2_q <= vcoS1_q;
      vcoS3_q <= vcoS2_q;
    end
  end

  // edges only count when slower than sys_clk/2; fast inputs need an analog prescaler first
  wire refEdge = refS2_q & ~refS3_q;
  wire vcoEdge = vcoS2_q & ~vcoS3_q;

  // optional fixed divide-by-two on the rf path
  reg  halfPhase_q;
  wire rfPulse = rfHalfSel ? (vcoEdge & halfPhase_q) : vcoEdge;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfPhase_q <= 1'b0;
    end else if (vcoEdge) begin
      halfPhase_q <= ~halfPhase_q;
    end
  end

  wire refDivPulse;
  pulse_divider #(
    .WIDTH (`REF_DIV_W)
  ) refDivider (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pulseIn    (refEdge),
    .ratio      (refRatio),
    .pulseOut_q (refDivPulse)
  );

  // fractional modulator: mode A first order, mode B two-stage cascade
  reg  [`FRAC_W-1:0]   acc1_q;
  reg  [`FRAC_W-1:0]   acc2_q;
  reg                  carry2Prev_q;
  wire [`FRAC_W:0]     sum1 = {1'b0, acc1_q} + {1'b0, fbFraction};
  wire [`FRAC_W:0]     sum2 = {1'b0, acc2_q} + {1'b0, sum1[`FRAC_W-1:0]};
  wire                 modeA = (modulatorMode == `MOD_MODE_A);
  reg  [`FB_DIV_W-1:0] fbRatio_q;
  reg  [`FB_DIV_W-1:0] ratioNext;
  wire                 fbDivPulse;

  // step stays within -1..+2, inside the +/-4 swing the average must allow for
  always @* begin
    ratioNext = fbInteger;
    if (fracEnable) begin
      if (modeA) begin
        ratioNext = fbInteger + {{(`FB_DIV_W-1){1'b0}}, sum1[`FRAC_W]};
      end else begin
        ratioNext = fbInteger + {{(`FB_DIV_W-1){1'b0}}, sum1[`FRAC_W]}
                  + {{(`FB_DIV_W-1){1'b0}}, sum2[`FRAC_W]}
                  - {{(`FB_DIV_W-1){1'b0}}, carry2Prev_q};
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc1_q       <= {`FRAC_W{1'b0}};
      acc2_q       <= {`FRAC_W{1'b0}};
      carry2Prev_q <= 1'b0;
      fbRatio_q    <= {`FB_DIV_W{1'b0}};
    end else if (!fracEnable) begin
      acc1_q       <= {`FRAC_W{1'b0}};
      acc2_q       <= {`FRAC_W{1'b0}};
      carry2Prev_q <= 1'b0;
      fbRatio_q    <= fbInteger;
    end else if (fbDivPulse || fbRatio_q == {`FB_DIV_W{1'b0}}) begin
      acc1_q       <= sum1[`FRAC_W-1:0];
      acc2_q       <= modeA ? {`FRAC_W{1'b0}} : sum2[`FRAC_W-1:0];
      carry2Prev_q <= modeA ? 1'b0 : sum2[`FRAC_W];
      fbRatio_q    <= ratioNext;
    end
  end

  pulse_divider #(
    .WIDTH (`FB_DIV_W)
  ) fbDivider (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .pulseIn    (rfPulse),
    .ratio      (fbRatio_q),
    .pulseOut_q (fbDivPulse)
  );

  // phase detector: first arrival raises its request, both clear after trimmed delay
  reg       upReq_q;
  reg       dnReq_q;
  reg [2:0] resetCnt_q;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upReq_q    <= 1'b0;
      dnReq_q    <= 1'b0;
      resetCnt_q <= 3'h0;
    end else if (upReq_q && dnReq_q) begin
      if (resetCnt_q >= resetTrim) begin
        upReq_q    <= refDivPulse;
        dnReq_q    <= fbDivPulse;
        resetCnt_q <= 3'h0;
      end else begin
        resetCnt_q <= resetCnt_q + 3'h1;
      end
    end else begin
      upReq_q <= upReq_q | refDivPulse;
      dnReq_q <= dnReq_q | fbDivPulse;
    end
  end

  // pump drive: midpoint beats forces, forces beat the detector
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pumpRaiseOutput_q   <= 1'b0;
      pump_lower_output_q <= 1'b0;
      midSourceEnable_q   <= 1'b0;
    end else begin
      midSourceEnable_q <= detector_force_midpoint;
      if (detector_force_midpoint) begin
        pumpRaiseOutput_q   <= 1'b0;
        pump_lower_output_q <= 1'b0;
      end else if (pump_force_raise || pump_force_lower) begin
        pumpRaiseOutput_q   <= pump_force_raise;
        pump_lower_output_q <= pump_force_lower & ~pump_force_raise;
      end else begin
        pumpRaiseOutput_q   <= upReq_q & ~dnReq_q & pumpUpEnable;
        pump_lower_output_q <= dnReq_q & ~upReq_q & pumpDownEnable;
      end
    end
  end

  localparam integer ANA_CYC2 = 2 * ANA_CYC;

  // lock window length in half-cycles; multiplier code 0 is half a timer period
  reg  [`DIFF_W:0] timerCyc;
  reg  [`DIFF_W:0] windowHalf;

  always @* begin
    case (timerSpeed)
      2'h0:    timerCyc = T0_CYC[`DIFF_W:0];
      2'h1:    timerCyc = T1_CYC[`DIFF_W:0];
      2'h2:    timerCyc = T2_CYC[`DIFF_W:0];
      default: timerCyc = T3_CYC[`DIFF_W:0];
    endcase
    if (windowDigital) begin
      windowHalf = timerCyc << timerMultiplier;
    end else begin
      windowHalf = ANA_CYC2[`DIFF_W:0];
    end
  end

  reg  [2:0]         ldState_q;
  reg  [`DIFF_W-1:0] diff_q;
  reg  [`HIT_W-1:0]  hitCnt_q;
  reg                lockFlag_q;
  reg                arrive;
  reg                inWindow;
  wire [`HIT_W-1:0]  hitTarget = {{(`HIT_W-1){1'b0}}, 1'b1} << (hitCountSel + `HIT_SHIFT_BASE);
  wire [`HIT_W-1:0]  hitNext   = hitCnt_q + {{(`HIT_W-1){1'b0}}, 1'b1};

  // the next arrival of either signal ends the measurement; either order counts
  always @* begin
    arrive   = 1'b0;
    inWindow = 1'b0;
    case (ldState_q)
      S_IDLE: begin
        arrive   = refDivPulse & fbDivPulse;
        inWindow = 1'b1;
      end
      S_REFFIRST: begin
        arrive   = fbDivPulse | refDivPulse;
        inWindow = fbDivPulse & ({1'b0, diff_q, 1'b0} <= windowHalf);
      end
      S_VCOFIRST: begin
        arrive   = fbDivPulse | refDivPulse;
        inWindow = refDivPulse & ({1'b0, diff_q, 1'b0} <= windowHalf);
      end
      default: begin
        arrive   = 1'b0;
        inWindow = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ldState_q  <= S_IDLE;
      diff_q     <= {`DIFF_W{1'b0}};
      hitCnt_q   <= {`HIT_W{1'b0}};
      lockFlag_q <= 1'b0;
    end else if (!lockEnable) begin
      ldState_q  <= S_IDLE;
      diff_q     <= {`DIFF_W{1'b0}};
      hitCnt_q   <= {`HIT_W{1'b0}};
      lockFlag_q <= 1'b0;
    end else begin
      case (ldState_q)
        S_IDLE: begin
          diff_q <= {`DIFF_W{1'b0}};
          if (refDivPulse && !fbDivPulse) begin
            ldState_q <= S_REFFIRST;
          end else if (fbDivPulse && !refDivPulse) begin
            ldState_q <= S_VCOFIRST;
          end
        end
        S_REFFIRST, S_VCOFIRST: begin
          if (diff_q != `DIFF_MAX) begin
            diff_q <= diff_q + {{(`DIFF_W-1){1'b0}}, 1'b1};
          end
          if (arrive) begin
            ldState_q <= S_IDLE;
          end
        end
        default: begin
          ldState_q <= S_IDLE;
        end
      endcase
      if (arrive && inWindow) begin
        if (hitNext >= hitTarget) begin
          lockFlag_q <= 1'b1;
        end else begin
          hitCnt_q <= hitNext;
        end
      end else if (arrive) begin
        hitCnt_q   <= {`HIT_W{1'b0}};
        lockFlag_q <= 1'b0;
      end
    end
  end

  // shared pin routing and status
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockStatus_q             <= 1'b0;
      lock_or_serial_out_pin_q <= 1'b0;
      refDivPulse_q            <= 1'b0;
      fbDivPulse_q             <= 1'b0;
    end else begin
      lockStatus_q  <= lockFlag_q;
      refDivPulse_q <= refDivPulse;
      fbDivPulse_q  <= fbDivPulse;
      if (outSelect == `OUT_SEL_REFDIV) begin
        lock_or_serial_out_pin_q <= refDivPulse;
      end else if (outSelect == `OUT_SEL_FBDIV) begin
        lock_or_serial_out_pin_q <= fbDivPulse;
      end else if (!pinHoldLock) begin
        lock_or_serial_out_pin_q <= serialReadActive ? serialReadData : lockFlag_q;
      end else if (outSelect == `OUT_SEL_LOCK && pinLockGate) begin
        lock_or_serial_out_pin_q <= lockFlag_q;
      end else begin
        lock_or_serial_out_pin_q <= 1'b0;
      end
    end
  end
endmodule // pll_dividers_lock_detect
`default_nettype wire

// ===== bench/pll_dld_checker_asserts.sv
// checker for pump overrides, lock enable and shared pin routing
`timescale 1ns/1ps
`default_nettype none
`include "pll_ctrl_consts.vh"
module pll_dld_checker (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  pumpUpEnable,
  input wire logic                  pumpDownEnable,
  input wire logic                  pump_force_raise,
  input wire logic                  pump_force_lower,
  input wire logic                  detector_force_midpoint,
  input wire logic                  lockEnable,
  input wire logic [`OUT_SEL_W-1:0] outSelect,
  input wire logic                  pinHoldLock,
  input wire logic                  pinLockGate,
  input wire logic                  serialReadActive,
  input wire logic                  serialReadData,
  input wire logic                  pumpRaiseOutput_q,
  input wire logic                  pump_lower_output_q,
  input wire logic                  midSourceEnable_q,
  input wire logic                  lockStatus_q,
  input wire logic                  lock_or_serial_out_pin_q,
  input wire logic                  refDivPulse_q,
  input wire logic                  fbDivPulse_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire pin = lock_or_serial_out_pin_q;
  wire noForce = !detector_force_midpoint && !pump_force_raise && !pump_force_lower;
  wire raiseOnly = !detector_force_midpoint && pump_force_raise;
  wire lowerOnly = !detector_force_midpoint && !pump_force_raise && pump_force_lower;
  wire lockPath = outSelect == `OUT_SEL_LOCK && pinHoldLock && pinLockGate;
  wire serialPath = !pinHoldLock && serialReadActive && outSelect != `OUT_SEL_REFDIV
                    && outSelect != `OUT_SEL_FBDIV;
  // inputs held two edges so the registered outputs have settled
  AST_MID_OVERRIDE: assert property (detector_force_midpoint [*2] |->
    midSourceEnable_q && !pumpRaiseOutput_q && !pump_lower_output_q)
    else $error("midpoint override wrong");
  AST_FORCE_RAISE: assert property (raiseOnly [*2] |->
    pumpRaiseOutput_q && !pump_lower_output_q) else $error("force raise wrong");
  AST_FORCE_LOWER: assert property (lowerOnly [*2] |->
    pump_lower_output_q && !pumpRaiseOutput_q) else $error("force lower wrong");
  AST_UP_GATE: assert property ((noForce && !pumpUpEnable) [*2] |->
    !pumpRaiseOutput_q) else $error("raise output not gated");
  AST_DN_GATE: assert property ((noForce && !pumpDownEnable) [*2] |->
    !pump_lower_output_q) else $error("lower output not gated");
  AST_LOCK_OFF: assert property (!lockEnable [*2] |=> !lockStatus_q)
    else $error("lock flag while disabled");
  AST_REF_PIN: assert property ((outSelect == `OUT_SEL_REFDIV) [*2] |->
    pin == refDivPulse_q) else $error("pin not showing reference divider");
  AST_FB_PIN: assert property ((outSelect == `OUT_SEL_FBDIV) [*2] |->
    pin == fbDivPulse_q) else $error("pin not showing feedback divider");
  // pin and status are both loaded from the same flag at the same edge
  AST_LOCK_PIN: assert property (lockPath [*2] |-> pin == lockStatus_q)
    else $error("pin not showing lock");
  AST_SERIAL_PIN: assert property (serialPath [*2] |-> pin == $past(serialReadData))
    else $error("pin not showing read data");
  cover property ($rose(lockStatus_q));
  cover property (outSelect == `OUT_SEL_REFDIV && refDivPulse_q);
  cover property (serialPath [*2]);
endmodule // pll_dld_checker
bind pll_dividers_lock_detect pll_dld_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .pumpUpEnable(pumpUpEnable), .pumpDownEnable(pumpDownEnable),
  .pump_force_raise(pump_force_raise), .pump_force_lower(pump_force_lower),
  .detector_force_midpoint(detector_force_midpoint), .lockEnable(lockEnable),
  .outSelect(outSelect), .pinHoldLock(pinHoldLock), .pinLockGate(pinLockGate),
  .serialReadActive(serialReadActive), .serialReadData(serialReadData),
  .pumpRaiseOutput_q(pumpRaiseOutput_q), .pump_lower_output_q(pump_lower_output_q),
  .midSourceEnable_q(midSourceEnable_q), .lockStatus_q(lockStatus_q),
  .lock_or_serial_out_pin_q(lock_or_serial_out_pin_q), .refDivPulse_q(refDivPulse_q),
  .fbDivPulse_q(fbDivPulse_q));
`default_nettype wire

// ===== bench/pll_osc_model.sv
// behavioural reference and vco oscillators feeding the dividers
`timescale 1ns/1ps
`default_nettype none
module pll_osc_model #(
  parameter real HALF_NS = 50.0
) (
  input  wire logic vcoStall,
  output var  logic refIn,
  output var  logic vcoIn
);
  // 10 MHz both: comparison rate far below every mode limit
  // 3 ns start keeps edges clear of the 25 ns clock edges
  initial begin
    refIn = 1'b0;
    vcoIn = 1'b0;
    #3;
    forever begin
      refIn = ~refIn;
      // a stalled vco stops low, as a dead oscillator would
      vcoIn = ~vcoIn & ~vcoStall;
      #HALF_NS;
    end
  end
endmodule // pll_osc_model
`default_nettype wire

// ===== bench/pll_dividers_lock_detect_tb.sv
// self-checking bench for dividers, pump control and lock detector
`timescale 1ns/1ps
`default_nettype none
`include "pll_ctrl_consts.vh"
module pll_dividers_lock_detect_tb;
  logic sys_clk, rst_n, refIn, vcoIn, vcoStall, rfHalfSel, fracEnable;
  logic upEn, dnEn, fRaise, fLower, fMid, lockEnable, windowDigital;
  logic pinHoldLock, pinLockGate, serialReadActive, serialReadData;
  logic raiseQ, lowerQ, midQ, lockQ, pinQ, refP, fbP;
  logic [`REF_DIV_W-1:0] refRatio;
  logic [`FB_DIV_W-1:0]  fbInteger;
  logic [`OUT_SEL_W-1:0] outSelect;
  logic [2:0]            timerMultiplier, hitCountSel;
  logic [1:0]            modulatorMode;
  int err_total, total_checks, cyc, t0, g;
  int rr [3] = '{1, 2, 7};
  int fi [5] = '{16, 23, 20, 20, 20};
  logic hv [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic fe [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [1:0] md [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
  logic [4:0] pv [6] = '{5'h10, 5'h08, 5'h04, 5'h0C, 5'h00, 5'h1F};
  logic [2:0] pe [6] = '{3'h1, 3'h4, 3'h2, 3'h4, 3'h0, 3'h1};

  pll_osc_model osc (.vcoStall(vcoStall), .refIn(refIn), .vcoIn(vcoIn));
  pll_dividers_lock_detect uut (.sys_clk(sys_clk), .rst_n(rst_n), .refIn(refIn),
    .vcoIn(vcoIn), .refRatio(refRatio), .rfHalfSel(rfHalfSel), .fbInteger(fbInteger),
    .fbFraction(24'h000000), .fracEnable(fracEnable), .modulatorMode(modulatorMode),
    .resetTrim(3'h3), .pumpUpEnable(upEn), .pumpDownEnable(dnEn),
    .pump_force_raise(fRaise), .pump_force_lower(fLower), .detector_force_midpoint(fMid),
    .lockEnable(lockEnable), .windowDigital(windowDigital), .timerSpeed(2'h0),
    .timerMultiplier(timerMultiplier), .hitCountSel(hitCountSel), .outSelect(outSelect),
    .pinHoldLock(pinHoldLock), .pinLockGate(pinLockGate),
    .serialReadActive(serialReadActive), .serialReadData(serialReadData),
    .pumpRaiseOutput_q(raiseQ), .pump_lower_output_q(lowerQ), .midSourceEnable_q(midQ),
    .lockStatus_q(lockQ), .lock_or_serial_out_pin_q(pinQ), .refDivPulse_q(refP),
    .fbDivPulse_q(fbP));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the ceiling is about twice the expected run of some 20000 cycles;
  // non-blocking so the test process reads the count without a race
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_val({31'h00000000, got}, {31'h00000000, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // skips two pulses, the first of which may still follow the old ratio, then times one period
  task automatic pulse_gap(input logic useFb, output int gap);
    repeat (2) do @(posedge sys_clk); while ((useFb ? fbP : refP) !== 1'b1);
    gap = 0;
    do begin
      @(posedge sys_clk);
      gap++;
    end while ((useFb ? fbP : refP) !== 1'b1);
  endtask

  initial begin
    rst_n = 1'b0; vcoStall = 1'b0; rfHalfSel = 1'b0; fracEnable = 1'b0;
    upEn = 1'b1; dnEn = 1'b1; fRaise = 1'b0; fLower = 1'b0; fMid = 1'b0;
    lockEnable = 1'b0; windowDigital = 1'b1; timerMultiplier = 3'h7;
    pinHoldLock = 1'b0; pinLockGate = 1'b0; serialReadActive = 1'b0;
    serialReadData = 1'b0; refRatio = 14'h0010; fbInteger = 19'h00010;
    outSelect = 5'h00; hitCountSel = 3'h0; modulatorMode = 2'h0;
    step(8);
    rst_n <= 1'b1;
    step(1);
    check_val({raiseQ, lowerQ, midQ, lockQ, pinQ, refP, fbP}, 32'h00000000);
    $display("test reset done");
    outSelect <= `OUT_SEL_REFDIV;
    foreach (rr[i]) begin
      refRatio <= rr[i][13:0];
      pulse_gap(1'b0, g);
      check_val(g, rr[i] * 4);
    end
    $display("test reference divider done");
    outSelect <= `OUT_SEL_FBDIV;
    // ratios 16..23 integer, 40 total with halving, 20 average fractional
    foreach (fi[i]) begin
      fbInteger <= fi[i][18:0];
      rfHalfSel <= hv[i];
      fracEnable <= fe[i];
      modulatorMode <= md[i];
      pulse_gap(1'b1, g);
      check_val(g, fi[i] * (hv[i] ? 8 : 4));
    end
    $display("test feedback divider done");
    foreach (pv[i]) begin
      {fMid, fRaise, fLower, upEn, dnEn} <= pv[i];
      step(4);
      check_val({raiseQ, lowerQ, midQ}, pe[i]);
    end
    {fMid, fRaise, fLower, upEn, dnEn} <= 5'h03;
    $display("test pump control done");
    refRatio <= 14'h0010;
    fbInteger <= 19'h00010;
    rfHalfSel <= 1'b0;
    fracEnable <= 1'b0;
    outSelect <= 5'h00;
    lockEnable <= 1'b1;
    t0 = cyc;
    do step(1); while (lockQ !== 1'b1);
    // 64 hits one comparison period apart; the first pair closes within two periods
    check_bit(cyc - t0 >= 4032 && cyc - t0 <= 4224, 1'b1);
    outSelect <= `OUT_SEL_LOCK;
    pinHoldLock <= 1'b1;
    pinLockGate <= 1'b1;
    step(3);
    check_bit(pinQ, 1'b1);
    pinLockGate <= 1'b0;
    step(3);
    check_bit(pinQ, 1'b0);
    pinHoldLock <= 1'b0;
    serialReadActive <= 1'b1;
    step(3);
    check_bit(pinQ, 1'b0);
    serialReadActive <= 1'b0;
    step(3);
    check_bit(pinQ, 1'b1);
    vcoStall <= 1'b1;
    step(200);
    check_bit(lockQ, 1'b0);
    check_bit(pinQ, 1'b0);
    vcoStall <= 1'b0;
    do step(1); while (lockQ !== 1'b1);
    lockEnable <= 1'b0;
    step(3);
    check_bit(lockQ, 1'b0);
    lockEnable <= 1'b1;
    step(2000);
    check_bit(lockQ, 1'b0);
    $display("test lock detect done");
    // a second reset lines both dividers up, at most two cycles apart, so the
    // one-cycle analog window sees every arrival pair as a hit
    rst_n <= 1'b0;
    windowDigital <= 1'b0;
    hitCountSel <= 3'h1;
    step(3);
    rst_n <= 1'b1;
    step(1);
    check_val({raiseQ, lowerQ, midQ, lockQ, pinQ, refP, fbP}, 32'h00000000);
    t0 = cyc;
    do step(1); while (lockQ !== 1'b1);
    // 128 hits one comparison period apart, the first within about 80 cycles of release
    check_bit(cyc - t0 >= 8128 && cyc - t0 <= 8320, 1'b1);
    $display("test analog window done");
    report_and_stop();
  end
endmodule // pll_dividers_lock_detect_tb
`default_nettype wire
